/* dis_pkg.sv */
// Package: constants and carriers for the DDR3 init and mode-register block
`default_nettype none
package dis_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_INIT_US = 500;
    localparam int T_INIT_CYC = (T_INIT_US * 1000) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W = 17;
    localparam logic [7:0] TXPR_TCK = 8'h05;
    localparam logic [15:0] TDLLK_RST = 16'h0200;
    localparam logic [15:0] TZQINIT_RST = 16'h0200;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MR0 = 8'h04;
    localparam logic [7:0] OFS_MR1 = 8'h08;
    localparam logic [7:0] OFS_MR2 = 8'h0C;
    localparam logic [7:0] OFS_MR3 = 8'h10;
    localparam logic [7:0] OFS_ACCESS = 8'h14;
    localparam logic [7:0] OFS_ERR = 8'h18;
    localparam logic [7:0] OFS_TDLLK = 8'h1C;
    localparam logic [7:0] OFS_TZQINIT = 8'h20;

    // Error bits
    localparam int ERR_ORDER = 0;
    localparam int ERR_EARLY_CKE = 1;
    localparam int ERR_NOT_IDLE = 2;
    localparam int ERR_EARLY_MRS = 3;

    // Mode register fields
    localparam int MR0_DLL_RST = 8;
    localparam int MR1_DLL_DIS = 0;
    localparam int MR0_BT = 3;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_BC4 = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_RESET, PH_WAIT_CKE, PH_XPR, PH_MR, PH_ZQ, PH_CAL, PH_READY
    } dis_phase_t;

    typedef struct packed {
        logic reset_n;
        logic cke;
        logic odt;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [14:0] addr;
    } dis_pins_t;

    typedef struct packed {
        logic is_write;
        logic auto_pre;
        logic chop;
        logic [2:0] bank;
        logic [10:0] col;
    } dis_access_t;
endpackage : dis_pkg
`default_nettype wire

/* dis_init_seq.sv */
// Module: DDR3 device-side reset, init and mode-register sequencer
//
// Register access over APB and the register addresses were chosen for this implementation.
`default_nettype none
module dis_init_seq #(
    parameter int INIT_CYC = dis_pkg::T_INIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dis_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory pins from the controller
    input wire logic mem_ck,
    input wire dis_pkg::dis_pins_t mem_pins,
    // Device status
    output logic rtt_on,
    output logic dll_locked,
    output logic mem_ready
);
    import dis_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dis_pins_t sync1;
        dis_pins_t sync2;
        logic ck_s1;
        logic ck_s2;
        logic ck_prev;
        dis_phase_t phase;
        logic [INIT_CNT_W-1:0] init_cnt;
        logic [7:0] xpr_cnt;
        logic [1:0] mr_step;
        logic [3:0][14:0] mr;
        logic [7:0] bank_open;
        logic [7:0][14:0] bank_row;
        dis_access_t last;
        logic [15:0] dllk_cnt;
        logic [15:0] zq_cnt;
        logic dll_lock;
        logic zq_done;
        logic term;
        logic [3:0] err;
        logic [15:0] t_dllk;
        logic [15:0] t_zq;
        logic [31:0] rdata;
        logic ready_q;
        logic slverr;
        logic rdy;
    } dis_state_t;

    dis_state_t s;
    dis_state_t next_s;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        dis_pins_t p;
        logic ck_rise;
        logic cmd;
        logic [3:0] err_set;
        logic [3:0] err_clr;
        logic [1:0] want;
        logic [1:0] sel;
        logic wr_acc;
        p = s.sync2;
        ck_rise = s.ck_s2 & ~s.ck_prev;
        // Commands only count with CKE high and chip selected
        cmd = ck_rise & p.cke & ~p.cs_n;
        wr_acc = psel & penable & s.ready_q & pwrite;
        err_set = 4'h0;
        err_clr = 4'h0;
        want = 2'h0;
        sel = p.ba[1:0];
        next_s = s;
        // Pins cross from the link side; first stage feeds only the second
        next_s.sync1 = mem_pins;
        next_s.sync2 = s.sync1;
        next_s.ck_s1 = mem_ck;
        next_s.ck_s2 = s.ck_s1;
        next_s.ck_prev = s.ck_s2;

        unique case (s.mr_step)
            2'h0: want = 2'h2;
            2'h1: want = 2'h3;
            2'h2: want = 2'h1;
            2'h3: want = 2'h0;
        endcase

        // Wait counters tick on link clock edges
        if (ck_rise && s.xpr_cnt != 8'hFF)
            next_s.xpr_cnt = s.xpr_cnt + 8'h01;
        if (ck_rise && s.dllk_cnt != 16'h0000)
        begin
            next_s.dllk_cnt = s.dllk_cnt - 16'h0001;
            if (s.dllk_cnt == 16'h0001)
            begin
                next_s.dll_lock = 1'b1;
                next_s.mr[0][MR0_DLL_RST] = 1'b0;
            end
        end
        if (ck_rise && s.zq_cnt != 16'h0000)
        begin
            next_s.zq_cnt = s.zq_cnt - 16'h0001;
            if (s.zq_cnt == 16'h0001)
                next_s.zq_done = 1'b1;
        end

        if (!p.reset_n)
        begin
            // Mode registers keep stale contents: undefined after reset
            next_s.phase = PH_RESET;
            next_s.init_cnt = '0;
            next_s.mr_step = 2'h0;
            next_s.bank_open = 8'h00;
            next_s.dllk_cnt = 16'h0000;
            next_s.zq_cnt = 16'h0000;
            next_s.dll_lock = 1'b0;
            next_s.zq_done = 1'b0;
        end
        else
        begin
            unique case (s.phase)
                PH_RESET:
                    next_s.phase = PH_WAIT_CKE;
                PH_WAIT_CKE:
                begin
                    if (s.init_cnt < INIT_CNT_W'(INIT_CYC))
                        next_s.init_cnt = s.init_cnt + 1'b1;
                    if (ck_rise && p.cke)
                    begin
                        if (s.init_cnt < INIT_CNT_W'(INIT_CYC))
                            err_set[ERR_EARLY_CKE] = 1'b1;
                        next_s.phase = PH_XPR;
                        // Starts at one so an MRS exactly tXPR later is legal
                        next_s.xpr_cnt = 8'h01;
                    end
                end
                PH_CAL:
                    if (s.dll_lock && s.zq_done)
                        next_s.phase = PH_READY;
                default:
                    next_s.phase = s.phase;
            endcase

            if (cmd && s.phase != PH_RESET && s.phase != PH_WAIT_CKE)
            begin
                unique case ({p.ras_n, p.cas_n, p.we_n})
                    3'b000:
                    begin
                        // Mode register set; open rows untouched
                        next_s.mr[sel] = p.addr;
                        if (p.ba[2])
                            err_set[ERR_ORDER] = 1'b1;
                        if (sel == 2'h0 && p.addr[MR0_DLL_RST])
                        begin
                            next_s.dllk_cnt = s.t_dllk;
                            next_s.dll_lock = 1'b0;
                        end
                        if (s.phase == PH_XPR || s.phase == PH_MR)
                        begin
                            if (s.xpr_cnt < TXPR_TCK)
                                err_set[ERR_EARLY_MRS] = 1'b1;
                            if (sel != want)
                                err_set[ERR_ORDER] = 1'b1;
                            next_s.mr_step = s.mr_step + 2'h1;
                            next_s.phase = (s.mr_step == 2'h3) ? PH_ZQ : PH_MR;
                        end
                        else if (s.bank_open != 8'h00)
                            err_set[ERR_NOT_IDLE] = 1'b1;
                    end
                    3'b011:
                    begin
                        next_s.bank_open[p.ba] = 1'b1;
                        next_s.bank_row[p.ba] = p.addr;
                    end
                    3'b010:
                        if (p.addr[10])
                            next_s.bank_open = 8'h00;
                        else
                            next_s.bank_open[p.ba] = 1'b0;
                    3'b100, 3'b101:
                    begin
                        next_s.last.is_write = ~p.we_n;
                        next_s.last.bank = p.ba;
                        next_s.last.col = {p.addr[11], p.addr[9:0]};
                        next_s.last.auto_pre = p.addr[10];
                        if (s.mr[0][1:0] == BL_OTF)
                            next_s.last.chop = ~p.addr[12];
                        else
                            next_s.last.chop = (s.mr[0][1:0] == BL_BC4);
                        if (p.addr[10])
                            next_s.bank_open[p.ba] = 1'b0;
                    end
                    3'b110:
                        if (s.phase == PH_ZQ && p.addr[10])
                        begin
                            next_s.zq_cnt = s.t_zq;
                            next_s.zq_done = 1'b0;
                            next_s.phase = PH_CAL;
                        end
                    default:
                        next_s.phase = next_s.phase;
                endcase
            end
        end

        // Termination off until CKE has been seen high after reset
        next_s.term = p.reset_n && p.odt && s.phase != PH_RESET &&
            s.phase != PH_WAIT_CKE;

        // --------------------------------------------------------------
        // APB: one wait state, answer registered
        // --------------------------------------------------------------
        next_s.ready_q = psel & penable & ~s.ready_q;
        if (psel && penable && !s.ready_q)
        begin
            next_s.slverr = 1'b0;
            next_s.rdata = 32'h0000_0000;
            unique case (paddr)
                OFS_STATUS:
                    next_s.rdata = {19'h00000, s.mr_step, s.mr[0][MR0_BT],
                        s.mr[0][1:0], s.term, s.phase == PH_READY,
                        s.zq_done, s.dll_lock, 1'b0, s.phase};
                OFS_MR0: next_s.rdata = {17'h00000, s.mr[0]};
                OFS_MR1: next_s.rdata = {17'h00000, s.mr[1]};
                OFS_MR2: next_s.rdata = {17'h00000, s.mr[2]};
                OFS_MR3: next_s.rdata = {17'h00000, s.mr[3]};
                OFS_ACCESS: next_s.rdata = {14'h0000, s.last, 1'b0};
                OFS_ERR: next_s.rdata = {28'h0000000, s.err};
                OFS_TDLLK: next_s.rdata = {16'h0000, s.t_dllk};
                OFS_TZQINIT: next_s.rdata = {16'h0000, s.t_zq};
                default: next_s.slverr = 1'b1;
            endcase
        end
        if (wr_acc && paddr == OFS_ERR)
            err_clr = pwdata[3:0];
        if (wr_acc && paddr == OFS_TDLLK)
            next_s.t_dllk = pwdata[15:0];
        if (wr_acc && paddr == OFS_TZQINIT)
            next_s.t_zq = pwdata[15:0];
        // Set beats clear in the same cycle
        next_s.err = (s.err & ~err_clr) | err_set;
        next_s.rdy = (next_s.phase == PH_READY);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s <= '0;
            s.phase <= PH_RESET;
            s.t_dllk <= TDLLK_RST;
            s.t_zq <= TZQINIT_RST;
        end
        else
            s <= next_s;
    end

    assign prdata = s.rdata;
    assign pready = s.ready_q;
    assign pslverr = s.slverr;
    assign rtt_on = s.term;
    assign dll_locked = s.dll_lock;
    assign mem_ready = s.rdy;
endmodule : dis_init_seq
`default_nettype wire

/* dis_init_seq_asserts.sv */
// Checker: port-level properties of the init and mode-register sequencer
`default_nettype none
module dis_init_seq_asserts
    import dis_pkg::*;
#(
    parameter int INIT_CYC = 200
) (
    // Clock, reset and APB
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [dis_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Memory pins and status
    input wire dis_pkg::dis_pins_t mem_pins,
    input wire logic rtt_on,
    input wire logic dll_locked,
    input wire logic mem_ready
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    // Cycles since the pin reset let go, saturating
    logic [17:0] up_cnt;
    always_ff @(posedge clk)
        if (srst || !mem_pins.reset_n)
            up_cnt <= 18'h0;
        else if (up_cnt != 18'h3FFFF)
            up_cnt <= up_cnt + 18'h1;

    sequence s_acc_start;
        psel && penable && !$past(penable);
    endsequence
    sequence s_pin_rst;
        (!mem_pins.reset_n)[*6];
    endsequence

    a_ready_time: assert property (s_acc_start |=> pready)
        else $error("pready not one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property
        (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside an access phase");
    a_bad_addr: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > OFS_TZQINIT))
        else $error("pslverr does not match address map");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_odt_reset: assert property (s_pin_rst |-> !rtt_on)
        else $error("termination on during reset");
    a_init_clear: assert property
        (s_pin_rst |-> !mem_ready && !dll_locked)
        else $error("ready or lock kept through reset");
    a_ready_dll: assert property (mem_ready |-> dll_locked)
        else $error("ready without DLL lock");
    a_init_wait: assert property
        (up_cnt > 18'h8 && up_cnt < INIT_CYC |-> !mem_ready)
        else $error("ready before the init wait");
endmodule : dis_init_seq_asserts

bind dis_init_seq dis_init_seq_asserts #(.INIT_CYC(INIT_CYC))
    dis_init_seq_asserts_inst (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_pins(mem_pins), .rtt_on(rtt_on),
    .dll_locked(dll_locked), .mem_ready(mem_ready));
`default_nettype wire

/* dis_ctrl_model.sv */
// Memory controller model: link clock, reset, CKE, ODT and commands
`default_nettype none
module dis_ctrl_model
    import dis_pkg::*;
#(
    parameter int TMOD = 12
) (
    // Link side
    output var logic mem_ck,
    output var dis_pkg::dis_pins_t mem_pins
);
    timeunit 1ns;
    timeprecision 100ps;

    // ODT held high and static throughout init
    initial
    begin
        mem_ck = 1'b0;
        mem_pins = '{reset_n: 1'b0, odt: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
            cas_n: 1'b1, we_n: 1'b1, default: '0};
        #3;
        forever #62.5 mem_ck = ~mem_ck;
    end

    // Pins move on the falling edge, away from the sampling edge
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba,
        input logic [14:0] a);
        @(negedge mem_ck);
        {mem_pins.cs_n, mem_pins.ras_n, mem_pins.cas_n, mem_pins.we_n} =
            {1'b0, rcw};
        mem_pins.ba = ba;
        mem_pins.addr = a;
        @(negedge mem_ck);
        {mem_pins.ras_n, mem_pins.cas_n, mem_pins.we_n} = 3'h7;
        // NOP or Deselect, picked at random
        mem_pins.cs_n = 1'($urandom);
        mem_pins.ba = ~ba;
        mem_pins.addr = ~a;
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) @(negedge mem_ck);
    endtask : idle

    task automatic mrs(input logic [2:0] ba, input logic [14:0] a);
        cmd(3'h0, ba, a);
        idle(TMOD);
    endtask : mrs

    task automatic rst(input int n);
        @(negedge mem_ck);
        mem_pins.cke = 1'b0;
        idle(1);
        mem_pins.reset_n = 1'b0;
        idle(n);
        mem_pins.reset_n = 1'b1;
    endtask : rst

    task automatic cke_up(input int n);
        idle(n);
        mem_pins.cke = 1'b1;
    endtask : cke_up
endmodule : dis_ctrl_model
`default_nettype wire

/* dis_init_seq_tb_top.sv */
// Testbench: init sequencing, mode registers and APB access
`default_nettype none
module dis_init_seq_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dis_pkg::*;
    localparam int INIT_CYC = 200;
    localparam logic [32:0] ALL = 33'h1FFFFFFFF;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mem_ck, rtt_on, dll_locked, mem_ready;
    dis_pins_t mem_pins;
    int bad_count = 0;
    int total_checks = 0;
    logic [65:0] exp_q[$];
    logic [65:0] note;
    // Init order MR2, MR3, MR1, MR0; MR0 asks for DLL reset
    logic [14:0] mr_val [4] = '{15'h0010, 15'h0000, 15'h0022, 15'h1D09};
    logic [2:0] mr_sel [4] = '{3'h2, 3'h3, 3'h1, 3'h0};

    always #5 clk = ~clk;

    dis_init_seq #(.INIT_CYC(INIT_CYC)) dis_init_seq_inst (.clk(clk),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_ck(mem_ck), .mem_pins(mem_pins),
        .rtt_on(rtt_on), .dll_locked(dll_locked), .mem_ready(mem_ready));
    dis_ctrl_model dis_ctrl_model_inst (.mem_ck(mem_ck), .mem_pins(mem_pins));

    task automatic cmp(input string n, input logic [32:0] e, g, m);
        total_checks++;
        if ((g & m) !== (e & m))
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e & m, g & m);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
        int n = 0;
        if (!w)
            exp_q.push_back({e, m});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40)
            bad_count++;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
        apb(1'b0, a, 32'h0, e, m);
    endtask : rd

    task automatic pin(input string n, input logic e, input logic g);
        cmp(n, {32'h0, e}, {32'h0, g}, 33'h1);
    endtask : pin

    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Read results are matched against the oldest note
    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = exp_q.pop_front();
            cmp($sformatf("reg %h", paddr), note[65:33], {pslverr, prdata},
                note[32:0]);
        end

    initial
    begin
        #600000;
        bad_count++;
        give_verdict();
    end

    initial
    begin
        logic [14:0] a;
        logic [2:0] b;
        logic w;
        void'($urandom(10));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(OFS_STATUS, 33'h0, 33'h1000000FF);
        rd(OFS_TDLLK, 33'h200, ALL);
        rd(OFS_TZQINIT, 33'h200, ALL);
        rd(8'h40, 33'h100000000, ALL);
        apb(1'b1, OFS_TDLLK, {16'($urandom), 16'h0008}, 33'h0, 33'h0);
        rd(OFS_TDLLK, 33'h8, ALL);
        apb(1'b1, OFS_TZQINIT, 32'hC, 33'h0, 33'h0);
        rd(OFS_TZQINIT, 33'hC, ALL);
        dis_ctrl_model_inst.rst(1600);
        pin("rtt_on", 1'b0, rtt_on);
        dis_ctrl_model_inst.cke_up(5);
        dis_ctrl_model_inst.idle(2);
        rd(OFS_ERR, 33'h2, 33'h10000000F);
        apb(1'b1, OFS_ERR, $urandom | 32'h2, 33'h0, 33'h0);
        rd(OFS_ERR, 33'h0, 33'h10000000F);
        // Warm reset, then the full sequence
        dis_ctrl_model_inst.rst(1);
        dis_ctrl_model_inst.cke_up(20);
        dis_ctrl_model_inst.idle(2);
        pin("rtt_on", 1'b1, rtt_on);
        rd(OFS_STATUS, 33'h2, 33'h100000007);
        dis_ctrl_model_inst.idle(5);
        for (int i = 0; i < 4; i++)
            dis_ctrl_model_inst.mrs(mr_sel[i], mr_val[i]);
        dis_ctrl_model_inst.cmd(3'h6, 3'h0, 15'h0400);
        pin("mem_ready", 1'b0, mem_ready);
        dis_ctrl_model_inst.idle(30);
        pin("mem_ready", 1'b1, mem_ready);
        pin("dll_locked", 1'b1, dll_locked);
        rd(OFS_STATUS, 33'h5F6, 33'h1000007FF);
        rd(OFS_ERR, 33'h0, 33'h10000000F);
        for (int i = 0; i < 4; i++)
            rd(OFS_MR0 + {3'h0, mr_sel[i], 2'h0}, {18'h0, mr_val[i] &
                (mr_sel[i] == 3'h0 ? 15'h7EFF : 15'h7FFF)}, ALL);
        for (int i = 0; i < 4; i++)
        begin
            a = 15'($urandom);
            b = 3'($urandom);
            w = i[0];
            dis_ctrl_model_inst.cmd(3'h3, b, a);
            dis_ctrl_model_inst.idle(4);
            dis_ctrl_model_inst.cmd({2'b10, ~w}, b, a);
            dis_ctrl_model_inst.idle(1);
            rd(OFS_ACCESS, {15'h0, w, a[10], ~a[12], b, a[11], a[9:0], 1'b0},
                ALL);
            dis_ctrl_model_inst.cmd(3'h2, 3'h0, 15'h0400);
            dis_ctrl_model_inst.idle(4);
        end
        dis_ctrl_model_inst.cmd(3'h3, 3'h5, 15'h0123);
        dis_ctrl_model_inst.idle(4);
        dis_ctrl_model_inst.mrs(3'h2, mr_val[0]);
        rd(OFS_ERR, 33'h4, 33'h10000000F);
        dis_ctrl_model_inst.rst(1);
        pin("mem_ready", 1'b0, mem_ready);
        pin("dll_locked", 1'b0, dll_locked);
        // MR3 first and right after CKE: order and tXPR both broken
        dis_ctrl_model_inst.cke_up(20);
        dis_ctrl_model_inst.mrs(3'h3, 15'h0000);
        rd(OFS_ERR, 33'hD, 33'h10000000F);
        give_verdict();
    end
endmodule : dis_init_seq_tb_top
`default_nettype wire
